// file: rtl/tofrr_pkg.sv
`default_nettype none
package tofrr_pkg;
  // serial frame layout: first byte is a command, the rest are data bytes
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned CMD_WR_BIT = 6;
  localparam int unsigned BIT_CNT_W = 3;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // register offsets
  localparam logic [5:0] ADDR_OVF_LIMIT_HIGH = 6'h06;
  localparam logic [5:0] ADDR_OVF_LIMIT_LOW = 6'h07;
  localparam logic [5:0] ADDR_STOP_MASK_HIGH = 6'h08;
  localparam logic [5:0] ADDR_STOP_MASK_LOW = 6'h09;
  localparam logic [5:0] ADDR_FINE_TIME_ONE = 6'h10;
  localparam logic [5:0] ADDR_CLOCK_COUNT_ONE = 6'h11;
  localparam logic [5:0] ADDR_FINE_TIME_TWO = 6'h12;
  localparam logic [5:0] ADDR_CLOCK_COUNT_TWO = 6'h13;

  // reset values
  localparam logic [7:0] RST_OVF_LIMIT = 8'hFF;
  localparam logic [7:0] RST_STOP_MASK = 8'h00;
  localparam logic [23:0] RST_RESULT = 24'h000000;

  // result field layout
  localparam int unsigned RES_W = 24;
  localparam int unsigned FINE_W = 23;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned PARITY_BIT = 23;
  localparam int unsigned RSVD_W = 7;
  localparam logic [6:0] RSVD_VAL = 7'h00;
  localparam logic [1:0] BIDX_FIRST = 2'h0;
  localparam logic [1:0] BIDX_LAST = 2'h2;
  localparam logic [5:0] ADDR_STEP = 6'h01;
  localparam logic [1:0] BIDX_STEP = 2'h1;
  localparam logic [15:0] CNT_STEP = 16'h0001;
endpackage
`default_nettype wire

// file: rtl/tofrr_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
// byte-level serial slave: chip select low, data sampled on clock rise,
// output changes on clock fall, most significant bit first
module tofrr_serial_port (
  input wire logic ref_clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic csb_n, // chip select pin, active low
  input wire logic sclk, // serial clock pin
  input wire logic sdi, // serial data in pin
  input wire logic [7:0] tx_byte, // byte to send next, taken on rx_valid
  output logic sdo, // serial data out pin
  output logic sdo_oe, // output enable of sdo, high while driving
  output logic rx_valid, // one-cycle pulse, a byte was received
  output logic rx_first, // received byte is the first of the frame
  output logic [7:0] rx_byte // received byte
);
  typedef struct packed {
    logic [1:0] cs_sync;
    logic [1:0] ck_sync;
    logic [1:0] di_sync;
    logic ck_prev;
    logic [2:0] bit_cnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic first;
    logic valid;
    logic valid_first;
    logic [7:0] byte_q;
    logic dout;
    logic oe;
  } tofrr_sp_state_t;

  tofrr_sp_state_t st_q, st_d;
  logic ck_rise, ck_fall, cs_act;

  // pins are sampled twice before use; sclk must stay below ref_clk / 8
  always_comb begin
    st_d = st_q;
    st_d.cs_sync = {st_q.cs_sync[0], csb_n};
    st_d.ck_sync = {st_q.ck_sync[0], sclk};
    st_d.di_sync = {st_q.di_sync[0], sdi};
    st_d.ck_prev = st_q.ck_sync[1];
    st_d.valid = 1'b0;
    cs_act = ~st_q.cs_sync[1];
    ck_rise = st_q.ck_sync[1] & ~st_q.ck_prev;
    ck_fall = ~st_q.ck_sync[1] & st_q.ck_prev;
    st_d.oe = cs_act;
    if (!cs_act) begin
      st_d.bit_cnt = '0;
      st_d.first = 1'b1;
      st_d.shout = '0;
      st_d.dout = 1'b0;
    end else begin
      if (ck_rise) begin
        st_d.shin = {st_q.shin[6:0], st_q.di_sync[1]};
        st_d.bit_cnt = st_q.bit_cnt + 3'h1;
        if (st_q.bit_cnt == tofrr_pkg::BIT_LAST) begin
          st_d.valid = 1'b1;
          st_d.valid_first = st_q.first;
          st_d.byte_q = {st_q.shin[6:0], st_q.di_sync[1]};
          st_d.first = 1'b0;
        end
      end
      if (ck_fall) begin
        st_d.dout = st_q.shout[7];
        st_d.shout = {st_q.shout[6:0], 1'b0};
      end
      // the answer byte is taken as soon as the previous byte completes
      if (st_q.valid) begin
        st_d.shout = tx_byte;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.cs_sync <= 2'h3;
      st_q.first <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign sdo = st_q.dout;
  assign sdo_oe = st_q.oe;
  assign rx_valid = st_q.valid;
  assign rx_first = st_q.valid_first;
  assign rx_byte = st_q.byte_q;
endmodule
`default_nettype wire

// file: rtl/tofrr_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - overflow limit low byte at 07h, read-write, resets to FFh
// - stop mask high byte 08h, low byte 09h, read-write, reset 00h
// - fine-time results: 23-bit value in bits 22..0, parity in bit 23
// - clock count results: 16-bit count, bits 22..16 zero, parity bit 23
// - four results at 10h..13h, read-only, reset to zero
// - overflow limit high byte at 06h, read-write, reset FFh, forms 16 bits
// - counter reaching limit flags overflow and stops measurement one cycle later
module tofrr_regs (
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic csb_n, // serial chip select, active low
  input wire logic sclk, // serial clock
  input wire logic sdi, // serial data in
  output logic sdo, // serial data out
  output logic sdo_oe, // sdo output enable, high while driving
  input wire logic meas_run, // measurement running, level
  output logic meas_stop, // one-cycle pulse, stop the measurement
  output logic clock_overflow_flag, // sticky overflow flag
  input wire logic clock_overflow_clear, // clears the flag, pulse
  output logic [15:0] clock_overflow_limit, // 16-bit overflow limit
  output logic [15:0] clock_stop_mask, // 16-bit stop mask
  input wire logic load_one, // pulse, store first result pair
  input wire logic load_two, // pulse, store second result pair
  input wire logic [22:0] fine_time, // fine-time value to store
  input wire logic [15:0] clock_count // clock count value to store
);
  typedef struct packed {
    logic [7:0] lim_hi;
    logic [7:0] lim_lo;
    logic [7:0] mask_hi;
    logic [7:0] mask_lo;
    logic [23:0] ft1;
    logic [23:0] cc1;
    logic [23:0] ft2;
    logic [23:0] cc2;
    logic [5:0] addr;
    logic wr;
    logic [1:0] bidx;
    logic [15:0] cnt;
    logic hit;
    logic stop;
    logic flag;
  } tofrr_state_t;

  tofrr_state_t st_q, st_d;
  logic rx_valid, rx_first;
  logic [7:0] rx_byte, tx_byte;
  logic [15:0] limit;

  tofrr_serial_port u_port (
    .ref_clk(ref_clk),
    .srst(srst),
    .csb_n(csb_n),
    .sclk(sclk),
    .sdi(sdi),
    .tx_byte(tx_byte),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .rx_valid(rx_valid),
    .rx_first(rx_first),
    .rx_byte(rx_byte)
  );

  function automatic logic [23:0] mk_fine(input logic [22:0] v);
    mk_fine = {^v, v};
  endfunction

  function automatic logic [23:0] mk_count(input logic [15:0] v);
    mk_count = {^v, tofrr_pkg::RSVD_VAL, v};
  endfunction

  function automatic logic is_wide(input logic [5:0] a);
    is_wide = (a >= tofrr_pkg::ADDR_FINE_TIME_ONE) &&
              (a <= tofrr_pkg::ADDR_CLOCK_COUNT_TWO);
  endfunction

  // read value; unmapped offsets read as zero
  function automatic logic [23:0] read_reg(input tofrr_state_t s,
                                           input logic [5:0] a);
    read_reg = '0;
    unique case (a)
      tofrr_pkg::ADDR_OVF_LIMIT_HIGH: read_reg = {16'h0000, s.lim_hi};
      tofrr_pkg::ADDR_OVF_LIMIT_LOW: read_reg = {16'h0000, s.lim_lo};
      tofrr_pkg::ADDR_STOP_MASK_HIGH: read_reg = {16'h0000, s.mask_hi};
      tofrr_pkg::ADDR_STOP_MASK_LOW: read_reg = {16'h0000, s.mask_lo};
      tofrr_pkg::ADDR_FINE_TIME_ONE: read_reg = s.ft1;
      tofrr_pkg::ADDR_CLOCK_COUNT_ONE: read_reg = s.cc1;
      tofrr_pkg::ADDR_FINE_TIME_TWO: read_reg = s.ft2;
      tofrr_pkg::ADDR_CLOCK_COUNT_TWO: read_reg = s.cc2;
      default: read_reg = '0;
    endcase
  endfunction

  assign limit = {st_q.lim_hi, st_q.lim_lo};

  // frame decode, register writes, result loads and overflow watch
  always_comb begin
    logic [23:0] rv;
    rv = '0;
    st_d = st_q;
    st_d.stop = 1'b0;
    if (rx_valid) begin
      if (rx_first) begin
        st_d.addr = rx_byte[tofrr_pkg::ADDR_W-1:0];
        st_d.wr = rx_byte[tofrr_pkg::CMD_WR_BIT];
        st_d.bidx = tofrr_pkg::BIDX_FIRST;
      end else begin
        // writes to result offsets fall through: they are read-only
        if (st_q.wr) begin
          unique case (st_q.addr)
            tofrr_pkg::ADDR_OVF_LIMIT_HIGH: st_d.lim_hi = rx_byte;
            tofrr_pkg::ADDR_OVF_LIMIT_LOW: st_d.lim_lo = rx_byte;
            tofrr_pkg::ADDR_STOP_MASK_HIGH: st_d.mask_hi = rx_byte;
            tofrr_pkg::ADDR_STOP_MASK_LOW: st_d.mask_lo = rx_byte;
            default: st_d.wr = st_q.wr;
          endcase
        end
        // wide registers send three bytes, then the address steps on
        if (is_wide(st_q.addr) && st_q.bidx != tofrr_pkg::BIDX_LAST) begin
          st_d.bidx = st_q.bidx + tofrr_pkg::BIDX_STEP;
        end else begin
          st_d.bidx = tofrr_pkg::BIDX_FIRST;
          st_d.addr = st_q.addr + tofrr_pkg::ADDR_STEP;
        end
      end
    end
    // result pairs are stored with their parity at load time
    if (load_one) begin
      st_d.ft1 = mk_fine(fine_time);
      st_d.cc1 = mk_count(clock_count);
    end
    if (load_two) begin
      st_d.ft2 = mk_fine(fine_time);
      st_d.cc2 = mk_count(clock_count);
    end
    // reference-clock counter runs only while a measurement runs
    if (!meas_run) begin
      st_d.cnt = '0;
      st_d.hit = 1'b0;
    end else if (!st_q.hit) begin
      if (st_q.cnt == limit) begin
        st_d.hit = 1'b1;
        st_d.stop = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + tofrr_pkg::CNT_STEP;
      end
    end
    // a new overflow in the clear cycle wins over the clear
    st_d.flag = st_d.stop | (st_q.flag & ~clock_overflow_clear);
    // next byte out is picked from the address after this step
    rv = read_reg(st_q, st_d.addr);
    tx_byte = rv[7:0];
    if (is_wide(st_d.addr)) begin
      unique case (st_d.bidx)
        tofrr_pkg::BIDX_FIRST: tx_byte = rv[23:16];
        tofrr_pkg::BIDX_STEP: tx_byte = rv[15:8];
        default: tx_byte = rv[7:0];
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.lim_hi <= tofrr_pkg::RST_OVF_LIMIT;
      st_q.lim_lo <= tofrr_pkg::RST_OVF_LIMIT;
      st_q.mask_hi <= tofrr_pkg::RST_STOP_MASK;
      st_q.mask_lo <= tofrr_pkg::RST_STOP_MASK;
      st_q.ft1 <= tofrr_pkg::RST_RESULT;
      st_q.cc1 <= tofrr_pkg::RST_RESULT;
      st_q.ft2 <= tofrr_pkg::RST_RESULT;
      st_q.cc2 <= tofrr_pkg::RST_RESULT;
    end else begin
      st_q <= st_d;
    end
  end

  assign meas_stop = st_q.stop;
  assign clock_overflow_flag = st_q.flag;
  assign clock_overflow_limit = limit;
  assign clock_stop_mask = {st_q.mask_hi, st_q.mask_lo};

  // checks
  logic data_wr;
  assign data_wr = rx_valid & ~rx_first & st_q.wr;

  sequence seq_reach;
    meas_run && !st_q.hit && st_q.cnt == limit;
  endsequence

  sequence seq_stop_once;
    meas_stop && clock_overflow_flag ##1 !meas_stop;
  endsequence

  AST_RESET_VALUES: assert property (@(posedge ref_clk)
    $fell(srst) |->
      limit == {tofrr_pkg::RST_OVF_LIMIT, tofrr_pkg::RST_OVF_LIMIT} &&
      clock_stop_mask == {tofrr_pkg::RST_STOP_MASK, tofrr_pkg::RST_STOP_MASK})
    else $error("limit or mask reset value wrong");

  AST_LIMIT_LOW_WRITE: assert property (@(posedge ref_clk)
    disable iff (srst)
    data_wr && st_q.addr == tofrr_pkg::ADDR_OVF_LIMIT_LOW
    |=> clock_overflow_limit[7:0] == $past(rx_byte))
    else $error("limit low byte not written");

  AST_MASK_HIGH_WRITE: assert property (@(posedge ref_clk)
    disable iff (srst)
    data_wr && st_q.addr == tofrr_pkg::ADDR_STOP_MASK_HIGH
    |=> clock_stop_mask[15:8] == $past(rx_byte))
    else $error("mask high byte not written");

  AST_LIMIT_HIGH_WRITE: assert property (@(posedge ref_clk)
    disable iff (srst)
    data_wr && st_q.addr == tofrr_pkg::ADDR_OVF_LIMIT_HIGH
    |=> clock_overflow_limit[15:8] == $past(rx_byte))
    else $error("limit high byte not written");

  AST_FINE_LOAD: assert property (@(posedge ref_clk)
    disable iff (srst)
    load_one |=> st_q.ft1[22:0] == $past(fine_time))
    else $error("fine time one not loaded");

  AST_COUNT_RESERVED: assert property (@(posedge ref_clk)
    disable iff (srst)
    st_q.cc1[22:16] == 7'h00 && st_q.cc2[22:16] == 7'h00)
    else $error("reserved count bits not zero");

  AST_RESULT_READ_ONLY: assert property (@(posedge ref_clk)
    disable iff (srst)
    data_wr && is_wide(st_q.addr) && !load_one && !load_two
    |=> $stable(st_q.ft1) && $stable(st_q.cc1) && $stable(st_q.ft2) &&
    $stable(st_q.cc2))
    else $error("result changed by a write");

  AST_EVEN_PARITY: assert property (@(posedge ref_clk)
    disable iff (srst)
    ^st_q.ft1 == 1'b0 && ^st_q.cc1 == 1'b0 && ^st_q.ft2 == 1'b0 &&
    ^st_q.cc2 == 1'b0)
    else $error("result parity not even");

  AST_OVERFLOW_STOP: assert property (@(posedge ref_clk)
    disable iff (srst)
    seq_reach |=> seq_stop_once)
    else $error("overflow did not stop the measurement");

  AST_FLAG_STICKY: assert property (@(posedge ref_clk)
    disable iff (srst)
    clock_overflow_flag && !clock_overflow_clear |=> clock_overflow_flag)
    else $error("overflow flag lost");
endmodule
`default_nettype wire

// file: rtl/tofrr_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: verification/tofrr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the serial register port: mode 0, msb first
module tofrr_host_model (
  input wire logic ref_clk, // system clock of the device
  input wire logic sdo, // data from the device
  input wire logic sdo_oe, // high while the device drives sdo
  output logic csb_n, // chip select, active low
  output logic sclk, // serial clock, stands low outside frames
  output logic sdi // data to the device
);
  // slow phases leave room for the device's pin synchroniser
  localparam int HALF = 6;

  initial begin
    csb_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // one frame: command byte, then nb data bytes; pins move on falling edges
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                      input int nb, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd << (8 * (3 - nb))};
    rd = '0;
    @(negedge ref_clk);
    csb_n = 1'b0;
    repeat (HALF) @(negedge ref_clk);
    for (int i = 0; i < 8 * (nb + 1); i++) begin
      sdi = sh[31 - i];
      repeat (HALF) @(negedge ref_clk);
      sclk = 1'b1;
      // an undriven sdo is taken as unknown so it never matches
      rd = {rd[22:0], sdo_oe ? sdo : 1'bx};
      repeat (HALF) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk);
    csb_n = 1'b1;
    sdi = ~sdi; // no stale level while deselected
    repeat (HALF) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: verification/tofrr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tofrr_regs_tb_top;
  logic ref_clk, srst, csb_n, sclk, sdi, sdo, sdo_oe;
  logic meas_run, meas_stop, clock_overflow_flag, clock_overflow_clear;
  logic [15:0] clock_overflow_limit, clock_stop_mask, clock_count, c1, c2;
  logic load_one, load_two;
  logic [22:0] fine_time, f1, f2;
  int mismatches, n_checks, n;

  tofrr_regs tofrr_regs_i (.ref_clk(ref_clk), .srst(srst), .csb_n(csb_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .meas_run(meas_run), .meas_stop(meas_stop),
    .clock_overflow_flag(clock_overflow_flag),
    .clock_overflow_clear(clock_overflow_clear),
    .clock_overflow_limit(clock_overflow_limit),
    .clock_stop_mask(clock_stop_mask), .load_one(load_one),
    .load_two(load_two), .fine_time(fine_time), .clock_count(clock_count));

  tofrr_host_model tofrr_host_model_i (.ref_clk(ref_clk), .sdo(sdo),
    .sdo_oe(sdo_oe), .csb_n(csb_n), .sclk(sclk), .sdi(sdi));

  // 20 MHz
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr8(input logic [5:0] a, input logic [7:0] v);
    logic [23:0] rd;
    tofrr_host_model_i.xfer({2'h1, a}, {16'h0000, v}, 1, rd);
  endtask

  // results are three bytes wide, everything else one
  task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
    logic [23:0] rd;
    int nb;
    nb = (a >= tofrr_pkg::ADDR_FINE_TIME_ONE) ? 3 : 1;
    tofrr_host_model_i.xfer({2'h0, a}, 24'h000000, nb, rd);
    check((nb == 3) ? rd : {16'h0000, rd[7:0]}, exp);
  endtask

  task automatic load(input logic two, input logic [22:0] f,
                      input logic [15:0] c);
    @(negedge ref_clk);
    fine_time = f;
    clock_count = c;
    load_one = ~two;
    load_two = two;
    @(negedge ref_clk);
    load_one = 1'b0;
    load_two = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    meas_run = 1'b0;
    clock_overflow_clear = 1'b0;
    load_one = 1'b0;
    load_two = 1'b0;
    fine_time = '0;
    clock_count = '0;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
    // reset values at the ports and over the serial port
    check({8'h00, clock_overflow_limit}, 24'h00FFFF);
    check({8'h00, clock_stop_mask}, 24'h000000);
    rd_chk(6'h06, 24'h0000FF);
    rd_chk(6'h07, 24'h0000FF);
    rd_chk(6'h08, 24'h000000);
    rd_chk(6'h09, 24'h000000);
    for (int i = 0; i < 4; i++) begin
      rd_chk(6'h10 + i[5:0], 24'h000000);
    end
    // every read-write byte takes a distinct pattern
    wr8(6'h07, 8'hAA);
    wr8(6'h06, 8'h12);
    wr8(6'h08, 8'hC3);
    wr8(6'h09, 8'h5A);
    rd_chk(6'h07, 24'h0000AA);
    rd_chk(6'h06, 24'h000012);
    rd_chk(6'h08, 24'h0000C3);
    rd_chk(6'h09, 24'h00005A);
    check({8'h00, clock_overflow_limit}, 24'h0012AA);
    check({8'h00, clock_stop_mask}, 24'h00C35A);
    // a result ignores writes; an unmapped byte reads zero
    wr8(6'h10, 8'h55);
    rd_chk(6'h10, 24'h000000);
    rd_chk(6'h0A, 24'h000000);
    // first pair has even bit counts, second pair odd, so parity shows 1
    f1 = 23'h400001;
    c1 = 16'hFFFF;
    f2 = 23'h123456;
    c2 = 16'h8003;
    load(1'b0, f1, c1);
    load(1'b1, f2, c2);
    rd_chk(6'h10, 24'h400001);
    rd_chk(6'h11, 24'h00FFFF);
    rd_chk(6'h12, 24'h923456);
    rd_chk(6'h13, 24'h808003);
    // overflow at limit 3: stop comes L+1 edges after run rises
    wr8(6'h06, 8'h00);
    wr8(6'h07, 8'h03);
    @(negedge ref_clk);
    meas_run = 1'b1;
    n = 0;
    while (meas_stop !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(n[23:0], 24'h000004);
    check({23'h0, clock_overflow_flag}, 24'h000001);
    @(posedge ref_clk);
    #1;
    check({23'h0, meas_stop}, 24'h000000);
    @(negedge ref_clk);
    meas_run = 1'b0;
    clock_overflow_clear = 1'b1;
    @(negedge ref_clk);
    clock_overflow_clear = 1'b0;
    @(negedge ref_clk);
    check({23'h0, clock_overflow_flag}, 24'h000000);
    wrap_up();
  end
endmodule
`default_nettype wire
